// ==== logic/instr_decode_pkg.sv ====
// Package for the instruction word decode and timing block.
// Assumes a core that fetches one 14-bit word per instruction cycle.
`default_nettype none

package instr_decode_pkg;

	// ------------------------------------------------------------
	// Word layout
	// ------------------------------------------------------------
	localparam int WORD_W = 14;
	localparam int FILE_W = 7;
	localparam int BIT_W = 3;
	localparam int PHASE_W = 2;
	localparam logic [PHASE_W-1:0] PHASE_FIRST = 2'h0;
	localparam logic [PHASE_W-1:0] PHASE_READ = 2'h1;
	localparam logic [PHASE_W-1:0] PHASE_WRITE = 2'h3;
	localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;
	localparam int DEST_BIT = 7;
	localparam int PTR_BIT = 2;
	localparam int PTR_OFS_BIT = 6;
	localparam logic [FILE_W-1:0] ADDR_IND0 = 7'h00;
	localparam logic [FILE_W-1:0] ADDR_IND1 = 7'h01;
	localparam logic [WORD_W-1:0] RESET_WORD = 14'h0000;

	// ------------------------------------------------------------
	// Opcode patterns
	// ------------------------------------------------------------
	localparam logic [1:0] GRP_BYTE = 2'h0;
	localparam logic [1:0] GRP_BIT = 2'h1;
	localparam logic [1:0] BITOP_SKIP_CLEAR = 2'h2;
	localparam logic [1:0] BITOP_SKIP_SET = 2'h3;
	localparam logic [5:0] OP_DEC_SKIP = 6'h0b;
	localparam logic [5:0] OP_INC_SKIP = 6'h0f;
	localparam logic [6:0] OP_NO_FILE = 7'h00;
	localparam logic [6:0] OP_CLEAR_ACCUM = 7'h02;
	localparam logic [2:0] OP_CALL = 3'h4;
	localparam logic [2:0] OP_ABS_JUMP = 3'h5;
	localparam logic [4:0] OP_REL_JUMP = 5'h19;
	localparam logic [5:0] OP_EXIT_LIT = 6'h34;
	localparam logic [5:0] OP_IND_OFS = 6'h3f;
	localparam logic [WORD_W-1:0] OP_EXIT = 14'h0008;
	localparam logic [WORD_W-1:0] OP_INT_EXIT = 14'h0009;
	localparam logic [WORD_W-1:0] OP_CALL_ACCUM = 14'h000a;
	localparam logic [WORD_W-1:0] OP_ACCUM_REL = 14'h000b;
	localparam logic [9:0] OP_IND_MOVE = 10'h001;

	typedef enum logic [1:0] {FMT_BYTE, FMT_BIT, FMT_CTRL} fmt_t;
	typedef enum {ST_EXEC, ST_STALL, ST_FLUSH} seq_state_t;

endpackage : instr_decode_pkg

`default_nettype wire

// ==== logic/instr_word_decode_timing.sv ====
// Instruction word decoder and instruction cycle sequencer.
// Assumes word_in, skip_cond and ptr_in_prog are synchronous to clock.
//
// Summary of operation
// RULE_01: Words are 14 bits, no extension words.
// RULE_02: Single cycle except listed multi-cycle groups.
// RULE_03: Both subroutine jumps take two cycles.
// RULE_04: All three exits take two cycles.
// RULE_05: Jumps and taken skips take two cycles.
// RULE_06: Indirect access to program memory adds cycle.
// RULE_07: Four oscillator clocks per instruction cycle.
// RULE_08: File operand read, modified, then stored.
// RULE_09: Read happens even for write-only instructions.
// RULE_10: Destination bit zero accumulator, one file.
// RULE_11: File address field is seven bits.
// RULE_12: Bit index selects one of eight.
// RULE_13: Pointer number picks one of two.
// RULE_14: Mode field selects pre/post increment/decrement.
// RULE_15: Don't-care bits never change execution.
// RULE_16: Taken skip discards next word as no-op.
// RULE_17: Format classified from leading opcode bits.
`default_nettype none

module instr_word_decode_timing (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Program memory side
	input wire logic [instr_decode_pkg::WORD_W-1:0] word_in,
	output logic word_taken,
	// Core status inputs
	input wire logic skip_cond,
	input wire logic [1:0] ptr_in_prog,
	// Timing outputs
	output logic [instr_decode_pkg::PHASE_W-1:0] phase,
	output logic instr_done,
	output logic flush,
	output logic stall,
	// Decoded fields
	output logic [1:0] format,
	output logic [instr_decode_pkg::FILE_W-1:0] file_addr,
	output logic [instr_decode_pkg::BIT_W-1:0] bit_idx,
	output logic dest_file,
	output logic ptr_sel,
	output logic [1:0] ptr_mode,
	// File register strobes
	output logic file_rd,
	output logic file_wr
);

	// ------------------------------------------------------------
	// Decode functions
	// ------------------------------------------------------------
	function automatic instr_decode_pkg::fmt_t fmt_of(input logic [instr_decode_pkg::WORD_W-1:0] w);
		if (w[13:12] == instr_decode_pkg::GRP_BYTE && w[13:7] != instr_decode_pkg::OP_NO_FILE)
			fmt_of = instr_decode_pkg::FMT_BYTE; // see RULE_17
		else if (w[13:12] == instr_decode_pkg::GRP_BIT)
			fmt_of = instr_decode_pkg::FMT_BIT;
		else
			fmt_of = instr_decode_pkg::FMT_CTRL;
	endfunction : fmt_of

	function automatic logic names_file(input logic [instr_decode_pkg::WORD_W-1:0] w);
		names_file = fmt_of(w) != instr_decode_pkg::FMT_CTRL && w[13:7] != instr_decode_pkg::OP_CLEAR_ACCUM; // see RULE_15
	endfunction : names_file

	function automatic logic is_skip(input logic [instr_decode_pkg::WORD_W-1:0] w);
		is_skip = (fmt_of(w) == instr_decode_pkg::FMT_BIT && w[11:10] inside
			{instr_decode_pkg::BITOP_SKIP_CLEAR, instr_decode_pkg::BITOP_SKIP_SET})
			|| w[13:8] == instr_decode_pkg::OP_DEC_SKIP || w[13:8] == instr_decode_pkg::OP_INC_SKIP;
	endfunction : is_skip

	function automatic logic is_flow(input logic [instr_decode_pkg::WORD_W-1:0] w);
		is_flow = w[13:11] == instr_decode_pkg::OP_CALL || w[13:11] == instr_decode_pkg::OP_ABS_JUMP
			|| w == instr_decode_pkg::OP_CALL_ACCUM // see RULE_03
			|| w == instr_decode_pkg::OP_EXIT || w == instr_decode_pkg::OP_INT_EXIT // see RULE_04
			|| w[13:8] == instr_decode_pkg::OP_EXIT_LIT
			|| w[13:9] == instr_decode_pkg::OP_REL_JUMP || w == instr_decode_pkg::OP_ACCUM_REL; // see RULE_05
	endfunction : is_flow

	function automatic logic ptr_of(input logic [instr_decode_pkg::WORD_W-1:0] w);
		if (w[13:4] == instr_decode_pkg::OP_IND_MOVE)
			ptr_of = w[instr_decode_pkg::PTR_BIT]; // see RULE_13
		else if (w[13:8] == instr_decode_pkg::OP_IND_OFS)
			ptr_of = w[instr_decode_pkg::PTR_OFS_BIT];
		else
			ptr_of = w[0];
	endfunction : ptr_of

	function automatic logic is_indirect(input logic [instr_decode_pkg::WORD_W-1:0] w);
		is_indirect = w[13:4] == instr_decode_pkg::OP_IND_MOVE || w[13:8] == instr_decode_pkg::OP_IND_OFS
			|| (names_file(w) && (w[6:0] == instr_decode_pkg::ADDR_IND0 || w[6:0] == instr_decode_pkg::ADDR_IND1));
	endfunction : is_indirect

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	instr_decode_pkg::seq_state_t state_reg, state_next;
	logic [instr_decode_pkg::PHASE_W-1:0] phase_reg, phase_next;
	logic [instr_decode_pkg::WORD_W-1:0] ir_reg, ir_next;
	logic taken_reg, taken_next;
	logic done_reg, done_next;
	logic end_cycle;
	logic flow_change;

	always_comb
	begin
		phase_next = phase_reg + 2'h1; // see RULE_07
		end_cycle = phase_reg == instr_decode_pkg::PHASE_LAST;
		flow_change = is_flow(ir_reg) || (is_skip(ir_reg) && skip_cond); // see RULE_16
		state_next = state_reg;
		ir_next = ir_reg;
		taken_next = 1'b0;
		done_next = 1'b0;
		if (end_cycle)
		begin
			unique case (state_reg)
				instr_decode_pkg::ST_EXEC:
				begin
					if (is_indirect(ir_reg) && ptr_in_prog[ptr_of(ir_reg)])
						state_next = instr_decode_pkg::ST_STALL; // see RULE_06
					else if (flow_change)
						state_next = instr_decode_pkg::ST_FLUSH; // see RULE_05
					else
						state_next = instr_decode_pkg::ST_EXEC; // see RULE_02
				end
				instr_decode_pkg::ST_STALL:
				begin
					if (flow_change)
						state_next = instr_decode_pkg::ST_FLUSH;
					else
						state_next = instr_decode_pkg::ST_EXEC;
				end
				instr_decode_pkg::ST_FLUSH:
					state_next = instr_decode_pkg::ST_EXEC;
			endcase
			if (state_next != instr_decode_pkg::ST_STALL)
			begin
				done_next = state_next != instr_decode_pkg::ST_FLUSH;
				ir_next = word_in; // see RULE_01
				taken_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= instr_decode_pkg::ST_FLUSH;
			phase_reg <= instr_decode_pkg::PHASE_FIRST;
			ir_reg <= instr_decode_pkg::RESET_WORD;
			taken_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			ir_reg <= ir_next;
			taken_reg <= taken_next;
			done_reg <= done_next;
		end
	end

	// ------------------------------------------------------------
	// Decoded fields and file strobes
	// ------------------------------------------------------------
	logic [1:0] format_reg, format_next;
	logic [instr_decode_pkg::FILE_W-1:0] file_addr_reg, file_addr_next;
	logic [instr_decode_pkg::BIT_W-1:0] bit_idx_reg, bit_idx_next;
	logic dest_file_reg, dest_file_next;
	logic ptr_sel_reg, ptr_sel_next;
	logic [1:0] ptr_mode_reg, ptr_mode_next;
	logic file_rd_reg, file_rd_next;
	logic file_wr_reg, file_wr_next;
	logic flush_reg, flush_next;
	logic stall_reg, stall_next;
	logic executing;

	always_comb
	begin
		executing = state_reg == instr_decode_pkg::ST_EXEC;
		format_next = fmt_of(ir_reg); // see RULE_17
		file_addr_next = ir_reg[instr_decode_pkg::FILE_W-1:0]; // see RULE_11
		bit_idx_next = ir_reg[9:7]; // see RULE_12
		ptr_sel_next = ptr_of(ir_reg); // see RULE_13
		ptr_mode_next = ir_reg[1:0]; // see RULE_14
		if (fmt_of(ir_reg) == instr_decode_pkg::FMT_BIT)
			dest_file_next = !is_skip(ir_reg);
		else
			dest_file_next = names_file(ir_reg) && ir_reg[instr_decode_pkg::DEST_BIT]; // see RULE_10
		file_rd_next = executing && names_file(ir_reg) && phase_next == instr_decode_pkg::PHASE_READ; // see RULE_09
		file_wr_next = executing && dest_file_next && phase_next == instr_decode_pkg::PHASE_WRITE; // see RULE_08
		flush_next = state_reg == instr_decode_pkg::ST_FLUSH; // see RULE_16
		stall_next = state_reg == instr_decode_pkg::ST_STALL;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			format_reg <= 2'h0;
			file_addr_reg <= 7'h00;
			bit_idx_reg <= 3'h0;
			dest_file_reg <= 1'b0;
			ptr_sel_reg <= 1'b0;
			ptr_mode_reg <= 2'h0;
			file_rd_reg <= 1'b0;
			file_wr_reg <= 1'b0;
			flush_reg <= 1'b0;
			stall_reg <= 1'b0;
		end
		else
		begin
			format_reg <= format_next;
			file_addr_reg <= file_addr_next;
			bit_idx_reg <= bit_idx_next;
			dest_file_reg <= dest_file_next;
			ptr_sel_reg <= ptr_sel_next;
			ptr_mode_reg <= ptr_mode_next;
			file_rd_reg <= file_rd_next;
			file_wr_reg <= file_wr_next;
			flush_reg <= flush_next;
			stall_reg <= stall_next;
		end
	end

	assign word_taken = taken_reg;
	assign phase = phase_reg;
	assign instr_done = done_reg;
	assign flush = flush_reg;
	assign stall = stall_reg;
	assign format = format_reg;
	assign file_addr = file_addr_reg;
	assign bit_idx = bit_idx_reg;
	assign dest_file = dest_file_reg;
	assign ptr_sel = ptr_sel_reg;
	assign ptr_mode = ptr_mode_reg;
	assign file_rd = file_rd_reg;
	assign file_wr = file_wr_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_phase_wrap;
		phase_reg == instr_decode_pkg::PHASE_LAST |=> phase_reg == instr_decode_pkg::PHASE_FIRST ##3 phase_reg == instr_decode_pkg::PHASE_LAST;
	endproperty
	a_phase_wrap: assert property (p_phase_wrap) else $error("Instruction cycle is not four clocks."); // see RULE_07

	property p_taken_spacing;
		taken_reg |=> !taken_reg [*3];
	endproperty
	a_taken_spacing: assert property (p_taken_spacing) else $error("Words taken closer than one cycle."); // see RULE_02

	property p_flow_two;
		executing && end_cycle && is_flow(ir_reg) && !is_indirect(ir_reg) |=> state_reg == instr_decode_pkg::ST_FLUSH [*4];
	endproperty
	a_flow_two: assert property (p_flow_two) else $error("Flow change lacks second cycle."); // see RULE_03

	property p_skip_taken;
		executing && end_cycle && is_skip(ir_reg) && skip_cond && !is_indirect(ir_reg) |=> ##1 flush_reg [*4];
	endproperty
	a_skip_taken: assert property (p_skip_taken) else $error("Taken skip did not flush."); // see RULE_16

	property p_plain_single;
		executing && end_cycle && !is_flow(ir_reg) && !is_skip(ir_reg) && !is_indirect(ir_reg) |=> ##1 !flush_reg && !stall_reg;
	endproperty
	a_plain_single: assert property (p_plain_single) else $error("Plain instruction took extra cycle."); // see RULE_02

	property p_ind_stall;
		executing && end_cycle && is_indirect(ir_reg) && ptr_in_prog[ptr_of(ir_reg)] |=> ##1 stall_reg [*4];
	endproperty
	a_ind_stall: assert property (p_ind_stall) else $error("Indirect program access not stalled."); // see RULE_06

	property p_wr_after_rd;
		file_wr_reg && names_file(ir_reg) |-> $past(file_rd_reg, 2);
	endproperty
	a_wr_after_rd: assert property (p_wr_after_rd) else $error("File write without prior read."); // see RULE_08

	property p_wr_dest;
		file_wr_reg |-> dest_file_reg && !flush_reg;
	endproperty
	a_wr_dest: assert property (p_wr_dest) else $error("File written with accumulator destination."); // see RULE_10

	property p_rd_always;
		executing && names_file(ir_reg) && phase_reg == instr_decode_pkg::PHASE_FIRST |=> file_rd_reg;
	endproperty
	a_rd_always: assert property (p_rd_always) else $error("Named file register not read."); // see RULE_09

	c_call: cover property (executing && end_cycle && ir_reg[13:11] == instr_decode_pkg::OP_CALL);
	c_skip: cover property (executing && end_cycle && is_skip(ir_reg) && skip_cond);
	c_stall: cover property (stall_reg ##4 flush_reg);

endmodule : instr_word_decode_timing

`default_nettype wire

// ==== sim/prog_mem_model.sv ====
// Program memory model that feeds instruction words to the decoder.
// Assumes the bench loads rom before reset is released.
`default_nettype none

module prog_mem_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Decoder side
	input wire logic word_taken,
	output logic [instr_decode_pkg::WORD_W-1:0] word_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [instr_decode_pkg::WORD_W-1:0] rom [0:63];
	logic [5:0] idx_reg;
	logic [5:0] idx_next;

	// The fetch index moves on once the decoder takes a word.
	always_comb
	begin
		idx_next = word_taken ? idx_reg + 6'h01 : idx_reg;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			idx_reg <= 6'h00;
		else
			idx_reg <= idx_next;
	end

	assign word_in = rom[idx_reg];
endmodule : prog_mem_model

`default_nettype wire

// ==== sim/tb_instr_word_decode_timing.sv ====
// Self-checking bench for the instruction word decoder and sequencer.
// Assumes prog_mem_model supplies words and the bench drives core status.
`default_nettype none

module tb_instr_word_decode_timing;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed
	{
		logic [13:0] w;
		logic sk;
		logic [1:0] pip;
	} note_t;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [13:0] word_in;
	logic word_taken, skip_cond, instr_done, flush, stall, dest_file, ptr_sel, file_rd, file_wr;
	logic [1:0] ptr_in_prog, phase, format, ptr_mode;
	logic [6:0] file_addr;
	logic [2:0] bit_idx;
	int fails = 0;
	int total_checks = 0;
	int seed = 36958;
	int i, k, r, v, n_clk, n_fl, n_st;
	logic seen_rd = 1'b0;
	logic seen_wr = 1'b0;
	logic have = 1'b0;
	logic live = 1'b0;
	logic fld = 1'b0;
	logic [1:0] ph;
	logic [3:0] d, dw;
	note_t cur, nd, q[$], ex[$];
	logic [13:0] ctl [8] = '{14'h2005, 14'h2805, 14'h3203, 14'h3412, 14'h0008, 14'h0009, 14'h000a, 14'h000b};

	always #12.5 clock = ~clock;

	instr_word_decode_timing dut (.clock(clock), .rst(rst), .word_in(word_in), .word_taken(word_taken),
		.skip_cond(skip_cond), .ptr_in_prog(ptr_in_prog), .phase(phase), .instr_done(instr_done),
		.flush(flush), .stall(stall), .format(format), .file_addr(file_addr), .bit_idx(bit_idx),
		.dest_file(dest_file), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode), .file_rd(file_rd), .file_wr(file_wr));
	prog_mem_model pm (.clock(clock), .rst(rst), .word_taken(word_taken), .word_in(word_in));

	// ------------------------------------------------------------
	// Expected behaviour of one word: flow change, extra cycle, bit op, file byte op
	// ------------------------------------------------------------
	function automatic logic [3:0] dec(input note_t n);
		logic bt;
		logic fb;
		logic sk;
		bt = n.w[13:12] == 2'h1;
		fb = n.w[13:12] == 2'h0 && n.w[11:9] != 3'h0;
		sk = (bt && n.w[11]) || (fb && n.w[11] && n.w[9:8] == 2'h3);
		dec[3] = n.w[13] || n.w[13:2] == 12'h002 || (sk && n.sk);
		dec[2] = (bt || fb) && n.w[6:1] == 6'h00 && n.pip[n.w[0]];
		dec[1] = bt;
		dec[0] = fb;
	endfunction : dec

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic wrap_up;
		if (fails == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// A flow change leaves one discarded word in memory behind it.
	task automatic add(input logic [13:0] w, input logic sk, input logic [1:0] pip);
		note_t n;
		n = '{w, sk, pip};
		q.push_back(n);
		ex.push_back(n);
		dw = dec(n);
		pm.rom[r] = w;
		r++;
		if (dw[3])
		begin
			pm.rom[r] = 14'h3fff;
			r++;
		end
	endtask : add

	// ------------------------------------------------------------
	// Output watcher
	// ------------------------------------------------------------
	always @(negedge clock)
	begin
		if (rst)
			live = 1'b0;
		else
		begin
			if (live)
				chk(phase, 2'(ph + 2'h1), "phase step");
			ph = phase;
			live = 1'b1;
			n_clk++;
			n_fl += flush;
			n_st += stall;
			seen_rd |= file_rd;
			seen_wr |= file_wr;
			if (fld)
			begin
				fld = 1'b0;
				if (cur.w[13] || d[1] || d[0])
					chk(format, cur.w[13] ? 2'h2 : {1'b0, cur.w[12]}, "format");
				if (d[1] || d[0])
					chk(file_addr, cur.w[6:0], "file addr");
				if (d[1])
					chk({bit_idx, dest_file}, {cur.w[9:7], ~cur.w[11]}, "bit fields");
				if (d[0])
					chk(dest_file, cur.w[7], "dest");
				if (cur.w[13:4] == 10'h001)
					chk({ptr_sel, ptr_mode}, cur.w[2:0], "ptr fields");
			end
			if (instr_done === 1'b1 && q.size() > 0)
			begin
				if (have)
				begin
					d = dec(cur);
					chk(n_clk, 4 + 4 * d[3] + 4 * d[2], "instr clocks");
					chk(n_fl, 4 * d[3], "flush clocks");
					chk(n_st, 4 * d[2], "stall clocks");
					chk(seen_rd, d[1] | d[0], "file read");
					chk(seen_wr, d[0] ? cur.w[7] : d[1] & ~cur.w[11], "file write");
				end
				cur = q.pop_front();
				have = 1'b1;
				d = dec(cur);
				chk(phase, instr_decode_pkg::PHASE_FIRST, "start phase");
				fld = 1'b1;
				n_clk = 0;
				n_fl = 0;
				n_st = 0;
				seen_rd = 1'b0;
				seen_wr = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Program build and status driver
	// ------------------------------------------------------------
	initial
	begin
		skip_cond = 1'b0;
		ptr_in_prog = 2'h0;
		r = 0;
		for (i = 0; i < 64; i++)
			pm.rom[i] = 14'h0000;
		add(14'h0103, 1'b0, 2'h0);
		add(14'h0100, 1'b0, 2'h0);
		for (i = 0; i < 8; i++)
			add(ctl[i], 1'b0, 2'h0);
		for (i = 0; i < 8; i++)
		begin
			v = $random(seed);
			add({2'h1, i[2:1], v[9:0]}, i[0], v[11:10]);
		end
		add(14'h1c00, 1'b1, 2'h1);
		for (i = 0; i < 4; i++)
		begin
			v = $random(seed);
			add({2'h0, i[1] ? 4'hf : 4'hb, v[7:0]}, i[0], 2'h0);
		end
		for (i = 0; i < 12; i++)
		begin
			v = $random(seed);
			k = 2 + (v[7:0] % 13);
			add({2'h0, k == 11 ? 4'h7 : k[3:0], v[18], i[0] ? {6'h00, v[8]} : v[15:9]}, 1'b0, v[17:16]);
		end
		for (i = 0; i < 8; i++)
		begin
			v = $random(seed);
			add({10'h001, v[3], i[2:0]}, 1'b0, 2'h0);
		end
		add(14'h0000, 1'b0, 2'h0);
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		for (k = 0; k < 4000 && q.size() > 0; k++)
		begin
			@(posedge clock);
			if (instr_done === 1'b1 && ex.size() > 0)
			begin
				nd = ex.pop_front();
				skip_cond <= nd.sk;
				ptr_in_prog <= nd.pip;
			end
		end
		if (q.size() > 0)
			fails++;
		wrap_up();
	end
endmodule : tb_instr_word_decode_timing

`default_nettype wire
